// ===== clkgen_regs.vh
`ifndef CLKGEN_REGS_VH
`define CLKGEN_REGS_VH

// register byte addresses
`define PLL_MULT_CTRL_ADDR   32'hFFFFF822
`define CPU_CLK_CTRL_ADDR    32'hFFFFF828
`define POWER_SAVE_CTRL_ADDR 32'hFFFFF1FE
`define POWER_KIND_ADDR      32'hFFFFF820
`define SETTLE_TIME_ADDR     32'hFFFFF6C0
`define PROT_CMD_ADDR        32'hFFFFF1FC
`define CLK_STATUS_ADDR      32'hFFFFF82C

// cpu_clock_ctrl fields
`define CPU_DIV_LSB          0
`define FB_RES_OFF_BIT       5
// pll_multiplier_ctrl fields
`define PLL_MULT_LSB         0
// power_save_ctrl fields
`define STANDBY_REQ_BIT      1
`define MASKABLE_MASK_BIT    4
`define NMI_MASK_BIT         5
// power_save_kind_reg / settle_time_reg fields
`define STANDBY_KIND_BIT     0
`define SETTLE_SEL_BIT       0

// reset values
`define CPU_CLK_CTRL_RST     8'h00
`define PLL_MULT_CTRL_RST    8'h00
`define POWER_SAVE_CTRL_RST  8'h00
`define POWER_KIND_RST       8'h00
`define SETTLE_TIME_RST      8'h01

// system clock as multiple of osc_clock, in quarters
`define MULT_X4_BYPASS       6'h04
`define MULT_X4_1P25         6'h05
`define MULT_X4_2P5          6'h0A
`define MULT_X4_5            6'h14
`define MULT_X4_10           6'h28

// timing counts in oscillator periods, and the prescaler one width in bits
`define SETTLE_SHORT_CYC     16384
`define SETTLE_LONG_CYC      65536
`define CPU_SWITCH_MAX_CYC   10
`define PERIPH_DIV_BITS      15

`endif

// ===== clock_generator_power_save.v
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_regs.vh"

module clock_generator_power_save #(
    parameter SETTLE_SHORT = `SETTLE_SHORT_CYC,
    parameter SETTLE_LONG  = `SETTLE_LONG_CYC
) (
    input  wire        clock,                 // oscillator reference clock
    input  wire        nrst,                  // async reset, active low
    input  wire [31:0] addr,                  // register byte address
    input  wire [7:0]  wr_data,               // write data
    input  wire [7:0]  wr_mask,               // bits to write, 8'hFF = byte
    input  wire        wr_en,                 // write strobe
    input  wire        rd_en,                 // read strobe
    output reg  [7:0]  rd_data,               // read data, cycle after rd_en
    input  wire        pll_bypass_select_pin, // 1 = clock-through mode
    input  wire        halt_req,              // cpu halt instruction pulse
    input  wire        nmi_req,               // nmi pin request
    input  wire        int_req,               // any maskable request
    output reg         osc_run,               // oscillator running
    output reg         pll_run,               // pll running
    output reg  [5:0]  sys_mult_x4,           // fxx / osc_clock, times 4
    output reg         sys_clk_on,            // fxx and fclk gate open
    output reg         periph_clk_on,         // peripheral clock gate open
    output reg  [14:0] periph_div,            // prescaler one taps
    output reg         fclk_tick,             // internal system clock enable
    output reg         cpu_tick,              // cpu clock enable
    output reg         feedback_resistor_off, // feedback resistor cut
    output reg  [2:0]  power_state            // current power state
);

    // halt stops only the cpu, idle everything but the oscillator and pll, stop
    // the oscillator too; settle waits for the oscillator after stop
    localparam [2:0] ST_RUN    = 3'h0;
    localparam [2:0] ST_HALT   = 3'h1;
    localparam [2:0] ST_IDLE   = 3'h2;
    localparam [2:0] ST_STOP   = 3'h3;
    localparam [2:0] ST_SETTLE = 3'h4;

    reg [7:0]  cpu_clock_ctrl_r;
    reg [7:0]  pll_multiplier_ctrl_r;
    reg [7:0]  power_save_ctrl_r;
    reg [7:0]  power_save_kind_reg_r;
    reg [7:0]  settle_time_reg_r;
    reg        prot_armed_r;
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [16:0] settle_cnt_r;
    reg [16:0] settle_cnt_nxt;
    reg [2:0]  pre2_cnt_r;
    reg [1:0]  cpu_div_act_r;
    reg [1:0]  pll_mult_act_r;
    reg        bypass_r;
    reg [7:0]  rd_data_nxt;

    function [7:0] merge;
        input [7:0] old;
        input [7:0] val;
        input [7:0] msk;
        begin
            merge = (old & ~msk) | (val & msk);
        end
    endfunction

    function [5:0] mult_x4;
        input       bypass;
        input [1:0] code;
        begin
            if (bypass) begin
                mult_x4 = `MULT_X4_BYPASS;
            end else begin
                case (code)
                    2'h0:    mult_x4 = `MULT_X4_1P25;
                    2'h1:    mult_x4 = `MULT_X4_2P5;
                    2'h2:    mult_x4 = `MULT_X4_5;
                    default: mult_x4 = `MULT_X4_10;
                endcase
            end
        end
    endfunction

    // low counter bits that must be zero for a tick, per divider code
    function [2:0] div_mask_of;
        input [1:0] code;
        begin
            case (code)
                2'h0:    div_mask_of = 3'h0;
                2'h1:    div_mask_of = 3'h1;
                2'h2:    div_mask_of = 3'h3;
                default: div_mask_of = 3'h7;
            endcase
        end
    endfunction

    // full address compare; anything unmapped reads zero and ignores
    // writes
    wire hit_cpu    = (addr == `CPU_CLK_CTRL_ADDR);
    wire hit_pll    = (addr == `PLL_MULT_CTRL_ADDR);
    wire hit_psc    = (addr == `POWER_SAVE_CTRL_ADDR);
    wire hit_kind   = (addr == `POWER_KIND_ADDR);
    wire hit_settle = (addr == `SETTLE_TIME_ADDR);
    wire hit_prot   = (addr == `PROT_CMD_ADDR);
    wire hit_status = (addr == `CLK_STATUS_ADDR);

    wire prot_ok  = wr_en & prot_armed_r;
    wire wr_cpu   = prot_ok & hit_cpu;
    wire wr_pll   = prot_ok & hit_pll;
    wire wr_psc   = prot_ok & hit_psc;

    // wake masks only matter in idle or stop; halt leaves on any
    // request so a masked source can still end a halt
    wire in_stby  = (state_r == ST_IDLE) | (state_r == ST_STOP);
    wire nmi_wake = nmi_req &
                    ~power_save_ctrl_r[`NMI_MASK_BIT];
    wire int_wake = int_req &
                    ~power_save_ctrl_r[`MASKABLE_MASK_BIT];
    wire stby_wake = in_stby & (nmi_wake | int_wake);
    wire any_req  = nmi_req | int_req;
    wire settle_long = settle_time_reg_r[`SETTLE_SEL_BIT];
    wire [16:0] settle_last = settle_long ?
                              SETTLE_LONG[16:0] - 17'h00001 :
                              SETTLE_SHORT[16:0] - 17'h00001;

    // protect key: any write to the command address arms the next access; a read in between disarms it
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prot_armed_r <= 1'b0;
        end else if (wr_en | rd_en) begin
            prot_armed_r <= wr_en & hit_prot;
        end
    end

    // each register keeps only its defined bits; reserved bits are
    // masked on every write so they always read back as zero
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_clock_ctrl_r <= `CPU_CLK_CTRL_RST;
        end else if (wr_cpu) begin
            cpu_clock_ctrl_r <= merge(cpu_clock_ctrl_r, wr_data,
                                      wr_mask) & 8'h23;
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pll_multiplier_ctrl_r <= `PLL_MULT_CTRL_RST;
        end else if (wr_pll) begin
            pll_multiplier_ctrl_r <= merge(pll_multiplier_ctrl_r,
                                           wr_data, wr_mask) & 8'h03;
        end
    end

    // a software write beats the hardware clear of the standby bit
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            power_save_ctrl_r <= `POWER_SAVE_CTRL_RST;
        end else if (wr_psc) begin
            power_save_ctrl_r <= merge(power_save_ctrl_r, wr_data,
                                       wr_mask) & 8'h32;
        end else if (stby_wake) begin
            power_save_ctrl_r[`STANDBY_REQ_BIT] <= 1'b0;
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            power_save_kind_reg_r <= `POWER_KIND_RST;
        end else if (wr_en & hit_kind) begin
            power_save_kind_reg_r <= merge(power_save_kind_reg_r,
                                           wr_data, wr_mask) & 8'h01;
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            settle_time_reg_r <= `SETTLE_TIME_RST;
        end else if (wr_en & hit_settle) begin
            settle_time_reg_r <= merge(settle_time_reg_r, wr_data,
                                       wr_mask) & 8'h01;
        end
    end

    // read mux; data stands one cycle and is zero otherwise
    always @* begin
        rd_data_nxt = 8'h00;
        if (rd_en) begin
            case (1'b1)
                hit_cpu:    rd_data_nxt = cpu_clock_ctrl_r;
                hit_pll:    rd_data_nxt = pll_multiplier_ctrl_r;
                hit_psc:    rd_data_nxt = power_save_ctrl_r;
                hit_kind:   rd_data_nxt = power_save_kind_reg_r;
                hit_settle: rd_data_nxt = settle_time_reg_r;
                hit_status: rd_data_nxt = {4'h0, bypass_r, state_r};
                default:    rd_data_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_data_nxt;
        end
    end

    // power state machine; standby entry waits for the request bit,
    // the kind bit is only looked at in that moment
    always @* begin
        state_nxt      = state_r;
        settle_cnt_nxt = settle_cnt_r;
        case (state_r)
            ST_RUN: begin
                if (power_save_ctrl_r[`STANDBY_REQ_BIT]) begin
                    if (power_save_kind_reg_r[`STANDBY_KIND_BIT]) begin
                        state_nxt = ST_STOP;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end else if (halt_req) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (any_req) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (stby_wake) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stby_wake) begin
                    state_nxt      = ST_SETTLE;
                    settle_cnt_nxt = 17'h00000;
                end
            end
            ST_SETTLE: begin
                if (settle_cnt_r >= settle_last) begin
                    state_nxt = ST_RUN;
                end else begin
                    settle_cnt_nxt = settle_cnt_r + 17'h00001;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // reset always lands in run, so no settle count follows it
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r      <= ST_RUN;
            settle_cnt_r <= 17'h00000;
        end else begin
            state_r      <= state_nxt;
            settle_cnt_r <= settle_cnt_nxt;
        end
    end

    // gates follow the next state so they switch on the same edge as
    // power_state and never lag the mode by a cycle
    wire osc_on_nxt  = (state_nxt != ST_STOP);
    wire sys_on_nxt  = (state_nxt == ST_RUN) |
                       (state_nxt == ST_HALT);
    wire cpu_on_nxt  = (state_nxt == ST_RUN);

    // prescaler two; divider swaps only at the wrap, within 8 cycles
    wire [2:0] div_mask = div_mask_of(cpu_div_act_r);
    wire pre2_hit = ((pre2_cnt_r & div_mask) == 3'h0);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pre2_cnt_r    <= 3'h0;
            cpu_div_act_r <= 2'h0;
        end else begin
            pre2_cnt_r <= pre2_cnt_r + 3'h1;
            if (pre2_cnt_r == 3'h7) begin
                cpu_div_act_r <= cpu_clock_ctrl_r[1:0];
            end
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // pin is sampled once so a change never splits one cycle
            bypass_r       <= 1'b0;
            pll_mult_act_r <= 2'h0;
            periph_div     <= 15'h0000;
        end else begin
            bypass_r       <= pll_bypass_select_pin;
            pll_mult_act_r <= pll_multiplier_ctrl_r[1:0];
            if (sys_on_nxt) begin
                periph_div <= periph_div + 15'h0001;
            end
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // during reset the oscillator runs but every gate is shut
            osc_run               <= 1'b1;
            pll_run               <= 1'b0;
            sys_mult_x4           <= `MULT_X4_BYPASS;
            sys_clk_on            <= 1'b0;
            periph_clk_on         <= 1'b0;
            fclk_tick             <= 1'b0;
            cpu_tick              <= 1'b0;
            feedback_resistor_off <= 1'b0;
            power_state           <= ST_RUN;
        end else begin
            osc_run       <= osc_on_nxt;
            pll_run       <= osc_on_nxt & ~bypass_r;
            sys_mult_x4   <= mult_x4(bypass_r,
                                     pll_mult_act_r);
            sys_clk_on    <= sys_on_nxt;
            periph_clk_on <= sys_on_nxt;
            fclk_tick     <= sys_on_nxt & pre2_hit;
            cpu_tick      <= cpu_on_nxt & pre2_hit;
            feedback_resistor_off <=
                cpu_clock_ctrl_r[`FB_RES_OFF_BIT];
            power_state   <= state_nxt;
        end
    end

endmodule
`default_nettype wire

// ===== clkgen_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_regs.vh"
module clkgen_properties #(
    parameter SETTLE_SHORT = 16,
    parameter SETTLE_LONG  = 64
) (
    input wire        clock,                 // clock
    input wire        nrst,                  // reset
    input wire [31:0] addr,                  // address
    input wire [7:0]  wr_data,               // write data
    input wire [7:0]  wr_mask,               // write mask
    input wire        wr_en,                 // write strobe
    input wire        rd_en,                 // read strobe
    input wire [7:0]  rd_data,               // read data
    input wire        pll_bypass_select_pin, // bypass pin
    input wire        osc_run,               // oscillator on
    input wire        pll_run,               // pll on
    input wire [5:0]  sys_mult_x4,           // multiplier
    input wire        sys_clk_on,            // system gate
    input wire        periph_clk_on,         // peripheral gate
    input wire        cpu_tick,              // cpu enable
    input wire        fclk_tick,             // fclk enable
    input wire        feedback_resistor_off, // resistor cut
    input wire [2:0]  power_state            // power state
);
    reg        key_r;
    reg        fb_r;
    reg        kind_r;
    reg        sel_r;
    reg [31:0] cnt_r;
    // shadow of the protect key and of the bits the checks depend on
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            key_r <= 1'h0;
            fb_r <= 1'h0;
            kind_r <= 1'h0;
            sel_r <= 1'h1;
            cnt_r <= 32'h0;
        end else begin
            if (wr_en || rd_en)
                key_r <= wr_en && addr == `PROT_CMD_ADDR;
            if (wr_en && key_r && addr == `CPU_CLK_CTRL_ADDR && wr_mask[5])
                fb_r <= wr_data[5];
            if (wr_en && addr == `POWER_KIND_ADDR && wr_mask[0])
                kind_r <= wr_data[0];
            if (wr_en && addr == `SETTLE_TIME_ADDR && wr_mask[0])
                sel_r <= wr_data[0];
            cnt_r <= (power_state == 3'h4) ? cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_bypass_mult: assert property (pll_bypass_select_pin [*3] |->
        sys_mult_x4 == `MULT_X4_BYPASS && !pll_run)
        else $error("bypass multiplier wrong");
    a_stop_osc: assert property (power_state == 3'h3 |-> !osc_run)
        else $error("oscillator runs in stop");
    a_idle_gates: assert property (power_state == 3'h2 |-> osc_run &&
        !sys_clk_on && !periph_clk_on && !cpu_tick && !fclk_tick)
        else $error("idle gating wrong");
    a_halt_cpu: assert property (power_state == 3'h1 |->
        !cpu_tick && sys_clk_on && periph_clk_on)
        else $error("halt gating wrong");
    a_settle_gated: assert property (power_state == 3'h4 |-> osc_run &&
        !sys_clk_on && !periph_clk_on && !cpu_tick)
        else $error("clock open during settle");
    a_read_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
    a_fb_follow: assert property (fb_r != feedback_resistor_off |=>
        fb_r == feedback_resistor_off)
        else $error("feedback resistor bit wrong");
    a_settle_len: assert property ($past(power_state) == 3'h4 &&
        power_state != 3'h4 |-> cnt_r == (sel_r ? SETTLE_LONG : SETTLE_SHORT))
        else $error("settle length wrong");
    a_standby_kind: assert property (power_state == 3'h0 && wr_en && key_r &&
        addr == `POWER_SAVE_CTRL_ADDR && wr_mask[1] && wr_data[1] |-> ##2
        power_state == (kind_r ? 3'h3 : 3'h2))
        else $error("standby entry wrong");
endmodule
bind clock_generator_power_save clkgen_properties #(
    .SETTLE_SHORT(SETTLE_SHORT), .SETTLE_LONG(SETTLE_LONG)) chk (
    .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_mask(wr_mask), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pll_bypass_select_pin(pll_bypass_select_pin), .osc_run(osc_run),
    .pll_run(pll_run), .sys_mult_x4(sys_mult_x4), .sys_clk_on(sys_clk_on),
    .periph_clk_on(periph_clk_on), .cpu_tick(cpu_tick),
    .fclk_tick(fclk_tick), .feedback_resistor_off(feedback_resistor_off),
    .power_state(power_state));
`default_nettype wire

// ===== clock_generator_power_save_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_regs.vh"
module clock_generator_power_save_tb_top;
    localparam SS = 16;
    localparam SL = 64;
    localparam [31:0] PM = `PLL_MULT_CTRL_ADDR;
    localparam [31:0] CC = `CPU_CLK_CTRL_ADDR;
    localparam [31:0] PS = `POWER_SAVE_CTRL_ADDR;
    localparam [31:0] PK = `POWER_KIND_ADDR;
    localparam [31:0] ST = `SETTLE_TIME_ADDR;
    localparam [31:0] PR = `PROT_CMD_ADDR;
    logic        clock, nrst, wr_en, rd_en, halt_req, nmi_req, int_req;
    logic        pll_bypass_select_pin, osc_run, pll_run, sys_clk_on;
    logic        periph_clk_on, fclk_tick, cpu_tick, feedback_resistor_off;
    logic [31:0] addr, a;
    logic [7:0]  wr_data, wr_mask, rd_data, m, d, e;
    logic [5:0]  sys_mult_x4;
    logic [14:0] periph_div, p0;
    logic [2:0]  power_state;
    logic        p;
    logic [56:0] rows [0:13];
    logic [5:0]  mt [0:3];
    int          failures, checks, cyc, i, c, f;
    clock_generator_power_save #(.SETTLE_SHORT(SS), .SETTLE_LONG(SL)) uut (
        .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_mask(wr_mask), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .pll_bypass_select_pin(pll_bypass_select_pin), .halt_req(halt_req),
        .nmi_req(nmi_req), .int_req(int_req), .osc_run(osc_run),
        .pll_run(pll_run), .sys_mult_x4(sys_mult_x4),
        .sys_clk_on(sys_clk_on), .periph_clk_on(periph_clk_on),
        .periph_div(periph_div), .fclk_tick(fclk_tick), .cpu_tick(cpu_tick),
        .feedback_resistor_off(feedback_resistor_off),
        .power_state(power_state));
    always #12.5 clock = ~clock;
    task test_done;
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            test_done;
        end
    end
    task chk(input string n, input logic [31:0] ex, input logic [31:0] g);
        checks = checks + 1;
        if (g !== ex) begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", n, ex, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task wr(input logic [31:0] ad, input logic [7:0] mk, input logic [7:0] dt);
        @(posedge clock);
        wr_en <= 1'h1;
        addr <= ad;
        wr_mask <= mk;
        wr_data <= dt;
        @(posedge clock);
        wr_en <= 1'h0;
    endtask
    task pw(input logic [31:0] ad, input logic [7:0] dt);
        wr(PR, 8'hFF, 8'h00);
        wr(ad, 8'hFF, dt);
    endtask
    task rd(input string n, input logic [31:0] ad, input logic [7:0] ex);
        @(posedge clock);
        rd_en <= 1'h1;
        addr <= ad;
        @(posedge clock);
        rd_en <= 1'h0;
        #1 chk(n, ex, rd_data);
    endtask
    // one-cycle pulse on {halt_req, nmi_req, int_req}
    task kick(input logic [2:0] s);
        @(posedge clock);
        {halt_req, nmi_req, int_req} <= s;
        @(posedge clock);
        {halt_req, nmi_req, int_req} <= 3'h0;
    endtask
    task ticks(input int n);
        c = 0;
        f = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (cpu_tick === 1'h1) c = c + 1;
            if (fclk_tick === 1'h1) f = f + 1;
        end
    endtask
    initial begin
        {clock, nrst, wr_en, rd_en, halt_req, nmi_req, int_req} = 7'h00;
        {pll_bypass_select_pin, addr, wr_data, wr_mask} = 49'h0;
        {failures, checks, cyc} = 96'h0;
        mt = '{`MULT_X4_1P25, `MULT_X4_2P5, `MULT_X4_5, `MULT_X4_10};
        // protect, address, mask, data, expected read-back
        rows = '{{1'h0, PM, 24'h000000}, {1'h0, CC, 24'h000000},
            {1'h0, PS, 24'h000000}, {1'h0, PK, 24'h000000},
            {1'h0, ST, 24'h000001}, {1'h0, 32'hFFFFF000, 24'hFFFF00},
            {1'h0, CC, 24'hFF0300}, {1'h1, CC, 24'hFFFF23},
            {1'h1, CC, 24'h200003}, {1'h0, PM, 24'hFF0300},
            {1'h1, PM, 24'hFFFF03}, {1'h1, PS, 24'hFF3030},
            {1'h0, ST, 24'hFF0000}, {1'h0, PK, 24'hFFFF01}};
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        for (i = 0; i < 14; i++) begin
            {p, a, m, d, e} = rows[i];
            if (p) wr(PR, 8'hFF, 8'h00);
            if (m != 8'h00) wr(a, m, d);
            rd("register", a, e);
        end
        for (i = 0; i < 4; i++) begin
            pw(PM, 8'(i));
            wt(3);
            chk("sys_mult_x4", mt[i], sys_mult_x4);
        end
        @(posedge clock) pll_bypass_select_pin <= 1'h1;
        wt(3);
        chk("bypass sys_mult_x4", 6'h04, sys_mult_x4);
        @(posedge clock) pll_bypass_select_pin <= 1'h0;
        for (i = 3; i >= 0; i--) begin
            pw(CC, 8'(i));
            wt(12);
            ticks(64);
            chk("cpu_tick count", 64 >> i, c);
            chk("fclk_tick count", 64 >> i, f);
        end
        pw(CC, 8'h20);
        wt(3);
        chk("feedback_resistor_off", 1'h1, feedback_resistor_off);
        p0 = periph_div;
        wt(8);
        chk("periph_div", 15'(p0 + 15'h8), periph_div);
        kick(3'h4);
        wt(3);
        chk("halt state", 3'h1, power_state);
        ticks(16);
        chk("halt cpu ticks", 0, c);
        chk("halt fclk ticks", 16, f);
        kick(3'h1);
        wt(3);
        chk("halt exit", 3'h0, power_state);
        wr(PK, 8'hFF, 8'h00);
        pw(PS, 8'h22);
        wt(2);
        chk("idle state", 3'h2, power_state);
        kick(3'h2);
        wt(3);
        chk("masked nmi", 3'h2, power_state);
        kick(3'h1);
        wt(3);
        chk("idle exit", 3'h0, power_state);
        rd("power_save_ctrl", PS, 8'h20);
        wr(PK, 8'hFF, 8'h01);
        pw(PS, 8'h12);
        wt(2);
        chk("stop state", 3'h3, power_state);
        kick(3'h1);
        wt(3);
        chk("masked int", 3'h3, power_state);
        kick(3'h2);
        wt(3);
        chk("settle state", 3'h4, power_state);
        chk("settle gate", 1'h0, sys_clk_on);
        wt(SS);
        chk("short settle end", 3'h0, power_state);
        wr(ST, 8'hFF, 8'h01);
        pw(PS, 8'h02);
        wt(2);
        kick(3'h1);
        wt(40);
        chk("long settle", 3'h4, power_state);
        wt(30);
        chk("long settle end", 3'h0, power_state);
        pw(PS, 8'h02);
        wt(2);
        @(posedge clock) nrst <= 1'h0;
        wt(2);
        @(posedge clock) nrst <= 1'h1;
        wt(2);
        chk("reset from stop", 3'h0, power_state);
        rd("settle_time_reg", ST, 8'h01);
        test_done;
    end
endmodule
`default_nettype wire
